/* frc_pin_model.sv */
/*
  frc_pin_model: keypad, control terminals and closed-loop source seen from the
  far side of the set-point controller.
  Assumes the bench gives the wanted pin levels; it moves them just after a
  rising edge and holds them until the bench asks for a change.
*/
module frc_pin_model
  import frc_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] pinReq,
  input wire logic signed [17:0] pidReq,
  output logic forwardRunTerminal,
  output logic reverseRunTerminal,
  output logic upTerminal,
  output logic downTerminal,
  output logic rampSetTerminal,
  output logic jogTerminal,
  output logic runKey,
  output logic multiPurposeKey,
  output logic [11:0] potLevel,
  output logic [16:0] analogInput,
  output logic signed [17:0] pidFreq,
  output logic signed [17:0] plcFreq,
  output logic [16:0] nvOffset
);
  // switches and keys are levels; a press is a high held for many cycles
  initial begin
    {multiPurposeKey, runKey, jogTerminal, rampSetTerminal} = 4'h0;
    {downTerminal, upTerminal, reverseRunTerminal, forwardRunTerminal} = 4'h0;
    pidFreq = 18'sh00000;
  end
  always @(posedge clk) begin
    {multiPurposeKey, runKey, jogTerminal, rampSetTerminal} <= pinReq[7:4];
    {downTerminal, upTerminal, reverseRunTerminal, forwardRunTerminal} <= pinReq[3:0];
    pidFreq <= pidReq;
  end
  // inputs the bench does not drive sit at fixed zero levels
  assign potLevel = 12'h000;
  assign analogInput = 17'h00000;
  assign plcFreq = 18'sh00000;
  assign nvOffset = 17'h00000;
endmodule

/* frc_pkg.sv */
/*
  frc_pkg: register map, field layouts, reset values and timing counts for the
  frequency set-point controller.
  Assumes a 20 MHz clock; frequencies are in 0.01 Hz units, times in 0.1 s units.
*/
package frc_pkg;
  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] FRC_CMD_OFF = 8'h00;
  localparam logic [7:0] FRC_SRC_OFF = 8'h04;
  localparam logic [7:0] FRC_MAXF_OFF = 8'h08;
  localparam logic [7:0] FRC_UPF_OFF = 8'h0c;
  localparam logic [7:0] FRC_LOWF_OFF = 8'h10;
  localparam logic [7:0] FRC_DSET_OFF = 8'h14;
  localparam logic [7:0] FRC_STORE_OFF = 8'h18;
  localparam logic [7:0] FRC_ACC_OFF = 8'h1c;
  localparam logic [7:0] FRC_JOG_OFF = 8'h20;
  localparam logic [7:0] FRC_KEY_OFF = 8'h24;
  localparam logic [7:0] FRC_STAT_OFF = 8'h28;
  // CMD register field positions
  localparam int FRC_CHAN_LSB = 0;
  localparam int FRC_LOWACT_LSB = 4;
  localparam int FRC_DIR_LSB = 8;
  localparam int FRC_MODE_LSB = 12;
  localparam int FRC_MACRO_LSB = 16;
  localparam int FRC_SERRUN_BIT = 24;
  localparam int FRC_SERREV_BIT = 25;
  // limits, 0.01 Hz units
  localparam logic [16:0] FRC_MAXF_FLOOR = 17'h01388; // 50.00 Hz
  localparam logic [16:0] FRC_MAXF_CEIL = 17'h1869c;  // 999.96 Hz
  localparam logic [16:0] FRC_UPF_FLOOR = 17'h0000a;  // 0.10 Hz
  localparam logic [16:0] FRC_MAXF_RST = 17'h01388;
  localparam logic [16:0] FRC_UPF_RST = 17'h01388;
  localparam logic [16:0] FRC_LOWF_RST = 17'h00000;
  localparam logic [16:0] FRC_DSET_RST = 17'h01388;
  // ramp times, 0.1 s units
  localparam logic [13:0] FRC_TIME_MIN = 14'h0001;
  localparam logic [13:0] FRC_TIME_MAX = 14'h270f;
  localparam logic [13:0] FRC_TIME_RST = 14'h0064; // 10.0 s
  // ramp tick: one tick per 0.1 s divided by 1000
  localparam int FRC_CLK_HZ = 20000000;
  localparam int FRC_TICK_US = 100; // ramp engine tick period
  localparam int FRC_TICK_CYC = FRC_CLK_HZ / 1000000 * FRC_TICK_US;
  localparam int FRC_UPDN_STEP = 1; // 0.01 Hz per tick of up/down terminal adjust
  localparam int FRC_UPDN_DIV = 1000; // clock cycles between adjust steps
  // enumerations
  typedef enum logic [1:0] {FRC_CH_KEY, FRC_CH_TERM, FRC_CH_SER, FRC_CH_RSV} frc_chan_type;
  localparam logic [2:0] FRC_SRC_POT = 3'h0;
  localparam logic [2:0] FRC_SRC_DIG = 3'h1;
  localparam logic [2:0] FRC_SRC_UPDN = 3'h2;
  localparam logic [2:0] FRC_SRC_AIN = 3'h3;
  localparam logic [2:0] FRC_SRC_COMB = 3'h4;
  localparam logic [2:0] FRC_SRC_COMM = 3'h6;
endpackage

/* frc_ramp.sv */
/*
  frc_ramp: linear ramp of the output frequency toward the target.
  Assumes target is already clamped; sync active-high reset.
*/
module frc_ramp
  import frc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  frc_ramp_if.ramp rp
);
  typedef struct packed {
    logic [35:0] acc;
    logic signed [17:0] freq;
    logic at;
  } frc_ramp_st_type;
  frc_ramp_st_type st_r, st_nxt;
  logic [35:0] span;

  // add maxFreq every clock, step once the sum reaches time*1000*tick cycles;
  // the span always exceeds maxFreq, so at most one step per clock is needed
  always_comb begin
    st_nxt = st_r;
    span = 36'(rp.rampTime) * 36'(FRC_TICK_CYC * 1000);
    if (st_r.freq == rp.target) begin
      st_nxt.acc = 36'h0; // no credit builds up while parked at the target
    end else begin
      st_nxt.acc = st_r.acc + 36'(rp.maxFreq);
      if (st_nxt.acc >= span) begin
        st_nxt.acc = st_nxt.acc - span;
        st_nxt.freq = (st_r.freq < rp.target) ? st_r.freq + 18'sd1 : st_r.freq - 18'sd1;
      end
    end
    if (st_nxt.freq > $signed({1'b0, rp.upLimit})) begin
      st_nxt.freq = $signed({1'b0, rp.upLimit});
    end
    st_nxt.at = (st_nxt.freq == rp.target);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rp.outFreq = st_r.freq;
  assign rp.atTarget = st_r.at;

  ramp_never_over_a: assert property (@(posedge clk) disable iff (rst)
    st_r.freq <= $signed({1'b0, rp.upLimit})) else $error("ramp above upper limit");
  ramp_unit_step_a: assert property (@(posedge clk) disable iff (rst)
    ($past(rp.upLimit) == rp.upLimit && !$past(rst)) |->
    (st_r.freq - $past(st_r.freq) <= 18'sd1)) else $error("ramp stepped too far");
endmodule

/* frc_ramp_if.sv */
/*
  frc_ramp_if: carries target, rate and result between set-point logic and ramp.
  Assumes one clock shared by both ends.
*/
interface frc_ramp_if;
  logic signed [17:0] target;
  logic [13:0] rampTime;
  logic [16:0] maxFreq;
  logic [16:0] upLimit;
  logic signed [17:0] outFreq;
  logic atTarget;
  modport ctl (output target, output rampTime, output maxFreq, output upLimit,
               input outFreq, input atTarget);
  modport ramp (input target, input rampTime, input maxFreq, input upLimit,
                output outFreq, output atTarget);
endinterface

/* frc_top.sv */
/*
  frc_top: set-point controller of a motor drive, with AHB-Lite registers.
  Assumes pins (terminals, keys) are asynchronous; one clock, sync reset.
*/
module frc_top
  import frc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic forwardRunTerminal,
  input wire logic reverseRunTerminal,
  input wire logic upTerminal,
  input wire logic downTerminal,
  input wire logic rampSetTerminal,
  input wire logic jogTerminal,
  input wire logic runKey,
  input wire logic multiPurposeKey,
  input wire logic [11:0] potLevel,
  input wire logic [16:0] analogInput,
  input wire logic signed [17:0] pidFreq,
  input wire logic signed [17:0] plcFreq,
  input wire logic [16:0] nvOffset,
  output logic running,
  output logic reversePhase,
  output logic [16:0] outFreq,
  output logic [1:0] ctrlMode
);
  // pins: 4 terminals + rampset + jog + 2 keys, three-stage synchronised
  localparam int NPIN = 8;
  typedef struct packed {
    logic [NPIN-1:0] s1, s2, s3, pin;
    logic aPhase;
    logic [7:0] aAddr;
    logic [31:0] rdata;
    logic [1:0] chan;
    logic [1:0] lowAct;
    logic [1:0] dir;
    logic [1:0] mode;
    logic [3:0] macro;
    logic serRun, serRev;
    logic [2:0] src;
    logic [16:0] maxF, upF, lowF, dset;
    logic [1:0] stUnit, stTen, stHun, stTho;
    logic [13:0] acc1, dec1, acc2, dec2, jogAcc, jogDec;
    logic signed [17:0] offset;
    logic [9:0] updnDiv;
    logic run, reverse_run_terminal, lowStop, started;
    logic [16:0] freqOut;
    logic revPh;
  } frc_st_type;
  frc_st_type st_r, st_nxt;
  frc_ramp_if rp();
  logic [16:0] wv;
  logic signed [17:0] mainF, setF, tgt, lim;
  logic runReq, revReq, wrNow, keyRun, keyStop;
  logic [NPIN-1:0] pinIn;

  assign pinIn = {multiPurposeKey, runKey, jogTerminal, rampSetTerminal,
                  downTerminal, upTerminal, reverseRunTerminal, forwardRunTerminal};

  frc_ramp u_ramp (.clk(clk), .rst(rst), .rp(rp));

  // main source selection and set-point build-up
  always_comb begin
    case (st_r.src)
      FRC_SRC_POT: mainF = 18'((30'(potLevel) * 30'(st_r.maxF)) >> 12);
      FRC_SRC_DIG, FRC_SRC_UPDN: mainF = $signed({1'b0, st_r.dset}) + st_r.offset;
      FRC_SRC_AIN: mainF = $signed({1'b0, analogInput});
      FRC_SRC_COMB: mainF = $signed({1'b0, analogInput}) + $signed({1'b0, st_r.dset});
      FRC_SRC_COMM: mainF = $signed({1'b0, st_r.dset});
      default: mainF = 18'sd0; // reserved codes 5 and 7
    endcase
    case (st_r.stTho)
      2'd1: setF = mainF + pidFreq;
      2'd2: setF = mainF + plcFreq;
      default: setF = mainF;
    endcase
    lim = (setF < 18'sd0) ? -setF : setF;
    // below-lower-limit action
    if (lim < $signed({1'b0, st_r.lowF})) begin
      case (st_r.lowAct)
        2'd1: lim = $signed({1'b0, st_r.lowF});
        default: lim = 18'sd0;
      endcase
    end
    if (lim > $signed({1'b0, st_r.upF})) begin
      lim = $signed({1'b0, st_r.upF});
    end
    tgt = (st_r.run && !(st_r.reverse_run_terminal && st_r.dir == 2'd2)) ? lim : 18'sd0;
  end

  assign rp.target = tgt;
  assign rp.maxFreq = st_r.maxF;
  assign rp.upLimit = st_r.upF;
  // jog set wins, then the terminal picks the second set
  assign rp.rampTime = (rp.outFreq < tgt) ?
    (st_r.pin[5] ? st_r.jogAcc : (st_r.pin[4] ? st_r.acc2 : st_r.acc1)) :
    (st_r.pin[5] ? st_r.jogDec : (st_r.pin[4] ? st_r.dec2 : st_r.dec1));

  // run command from the selected channel only
  always_comb begin
    keyRun = st_r.pin[6] && !st_nxt.pin[6];
    keyStop = st_r.pin[7] && !st_nxt.pin[7];
    case (st_r.chan)
      2'd0: begin
        runReq = keyRun ? 1'b1 : (keyStop ? 1'b0 : st_r.run);
        revReq = 1'b0;
      end
      2'd1: begin
        runReq = st_r.pin[0] ^ st_r.pin[1];
        revReq = st_r.pin[1];
      end
      2'd2: begin
        runReq = st_r.serRun;
        revReq = st_r.serRev;
      end
      default: begin
        runReq = 1'b0;
        revReq = 1'b0;
      end
    endcase
  end

  assign wrNow = st_r.aPhase;
  assign wv = hwdata[16:0];

  // bus slave, registers, synchronisers and digital set-point
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < NPIN; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) st_nxt.pin[i] = st_r.s3[i];
    end
    st_nxt.aPhase = hsel && hready && htrans[1] && hwrite;
    st_nxt.aAddr = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        FRC_CMD_OFF: st_nxt.rdata = {6'h00, st_r.serRev, st_r.serRun, 4'h0, st_r.macro,
          2'h0, st_r.mode, 2'h0, st_r.dir, 2'h0, st_r.lowAct, 2'h0, st_r.chan};
        FRC_SRC_OFF: st_nxt.rdata = {29'h0, st_r.src};
        FRC_MAXF_OFF: st_nxt.rdata = {15'h0, st_r.maxF};
        FRC_UPF_OFF: st_nxt.rdata = {15'h0, st_r.upF};
        FRC_LOWF_OFF: st_nxt.rdata = {15'h0, st_r.lowF};
        FRC_DSET_OFF: st_nxt.rdata = {15'h0, st_r.dset};
        FRC_STORE_OFF: st_nxt.rdata = {24'h0, st_r.stTho, st_r.stHun, st_r.stTen, st_r.stUnit};
        FRC_ACC_OFF: st_nxt.rdata = {2'h0, st_r.dec1, 2'h0, st_r.acc1};
        FRC_JOG_OFF: st_nxt.rdata = {2'h0, st_r.jogDec, 2'h0, st_r.jogAcc};
        FRC_KEY_OFF: st_nxt.rdata = {2'h0, st_r.dec2, 2'h0, st_r.acc2};
        FRC_STAT_OFF: st_nxt.rdata = {st_r.offset[17], st_r.run, st_r.reverse_run_terminal, st_r.lowStop,
          11'h0, st_r.freqOut};
        default: st_nxt.rdata = 32'h0;
      endcase
    end
    if (wrNow) begin
      case (st_r.aAddr)
        FRC_CMD_OFF: begin
          if (hwdata[1:0] <= 2'd2) st_nxt.chan = hwdata[1:0];
          if (hwdata[5:4] <= 2'd2) st_nxt.lowAct = hwdata[5:4];
          if (hwdata[9:8] <= 2'd2) st_nxt.dir = hwdata[9:8];
          if (hwdata[13:12] <= 2'd2) st_nxt.mode = hwdata[13:12];
          if (hwdata[19:16] <= 4'd10) st_nxt.macro = hwdata[19:16];
          st_nxt.serRun = hwdata[FRC_SERRUN_BIT];
          st_nxt.serRev = hwdata[FRC_SERREV_BIT];
        end
        FRC_SRC_OFF: st_nxt.src = hwdata[2:0];
        FRC_MAXF_OFF: begin
          if (wv >= FRC_MAXF_FLOOR && wv >= st_r.upF && wv <= FRC_MAXF_CEIL) st_nxt.maxF = wv;
        end
        FRC_UPF_OFF: begin
          if (wv >= FRC_UPF_FLOOR && wv >= st_r.lowF && wv <= st_r.maxF) st_nxt.upF = wv;
        end
        FRC_LOWF_OFF: begin
          if (wv <= st_r.upF) st_nxt.lowF = wv;
        end
        FRC_DSET_OFF: begin
          if (wv <= st_r.upF) st_nxt.dset = wv;
        end
        FRC_STORE_OFF: begin
          if (hwdata[7:6] <= 2'd2 && hwdata[5:4] <= 2'd1 && hwdata[3:2] <= 2'd1 &&
              hwdata[1:0] <= 2'd1) begin
            {st_nxt.stTho, st_nxt.stHun, st_nxt.stTen, st_nxt.stUnit} = hwdata[7:0];
          end
        end
        FRC_ACC_OFF: begin
          if (hwdata[13:0] >= FRC_TIME_MIN && hwdata[13:0] <= FRC_TIME_MAX) st_nxt.acc1 = hwdata[13:0];
          if (hwdata[29:16] >= FRC_TIME_MIN && hwdata[29:16] <= FRC_TIME_MAX) st_nxt.dec1 = hwdata[29:16];
        end
        FRC_JOG_OFF: begin
          if (hwdata[13:0] >= FRC_TIME_MIN && hwdata[13:0] <= FRC_TIME_MAX) st_nxt.jogAcc = hwdata[13:0];
          if (hwdata[29:16] >= FRC_TIME_MIN && hwdata[29:16] <= FRC_TIME_MAX) st_nxt.jogDec = hwdata[29:16];
        end
        FRC_KEY_OFF: begin
          if (hwdata[13:0] >= FRC_TIME_MIN && hwdata[13:0] <= FRC_TIME_MAX) st_nxt.acc2 = hwdata[13:0];
          if (hwdata[29:16] >= FRC_TIME_MIN && hwdata[29:16] <= FRC_TIME_MAX) st_nxt.dec2 = hwdata[29:16];
        end
        default: ;
      endcase
    end
    // up/down terminal adjustment of the offset, paced by a divider of clock cycles
    st_nxt.updnDiv = (st_r.updnDiv == 10'(FRC_UPDN_DIV - 1)) ? 10'h000 : st_r.updnDiv + 10'h001;
    if (st_r.updnDiv == 10'h000 && (st_r.src == FRC_SRC_UPDN || st_r.src == FRC_SRC_DIG)) begin
      if (st_r.pin[2] && !st_r.pin[3]) begin
        if ($signed({1'b0, st_r.dset}) + st_r.offset < $signed({1'b0, st_r.upF}))
          st_nxt.offset = st_r.offset + 18'(FRC_UPDN_STEP);
      end else if (st_r.pin[3] && !st_r.pin[2]) begin
        if (st_r.stHun == 2'd1 || $signed({1'b0, st_r.dset}) + st_r.offset > 18'sd0)
          st_nxt.offset = st_r.offset - 18'(FRC_UPDN_STEP);
      end
    end
    // run and stop
    st_nxt.lowStop = (st_r.lowAct == 2'd2) && (setF < $signed({1'b0, st_r.lowF}));
    st_nxt.run = runReq && !st_nxt.lowStop;
    st_nxt.reverse_run_terminal = revReq;
    if (st_r.run && !st_nxt.run && st_r.stTen == 2'd1) st_nxt.offset = 18'sd0;
    st_nxt.started = 1'b1;
    if (!st_r.started && st_r.stUnit == 2'd0) st_nxt.offset = $signed({1'b0, nvOffset});
    st_nxt.freqOut = rp.outFreq[16:0];
    // with reverse forbidden the phase order never flips
    st_nxt.revPh = (st_r.dir == 2'd1) ^ (st_r.reverse_run_terminal && st_r.dir != 2'd2);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.maxF <= FRC_MAXF_RST;
      st_r.upF <= FRC_UPF_RST;
      st_r.lowF <= FRC_LOWF_RST;
      st_r.dset <= FRC_DSET_RST;
      st_r.acc1 <= FRC_TIME_RST;
      st_r.dec1 <= FRC_TIME_RST;
      st_r.acc2 <= FRC_TIME_RST;
      st_r.dec2 <= FRC_TIME_RST;
      st_r.jogAcc <= FRC_TIME_RST;
      st_r.jogDec <= FRC_TIME_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign running = st_r.run;
  assign reversePhase = st_r.revPh;
  assign outFreq = st_r.freqOut;
  assign ctrlMode = st_r.mode;

  limits_ordered_a: assert property (@(posedge clk) disable iff (rst)
    st_r.lowF <= st_r.upF && st_r.upF <= st_r.maxF) else $error("limits out of order");
  maxf_range_a: assert property (@(posedge clk) disable iff (rst)
    st_r.maxF >= FRC_MAXF_FLOOR && st_r.maxF <= FRC_MAXF_CEIL) else $error("max freq range");
  bad_write_kept_a: assert property (@(posedge clk) disable iff (rst)
    (wrNow && st_r.aAddr == FRC_LOWF_OFF && wv > st_r.upF) |=> $stable(st_r.lowF))
    else $error("bad lower limit taken");
  chan_serial_a: assert property (@(posedge clk) disable iff (rst)
    (st_r.chan == 2'd2 && !st_r.serRun) |=> !st_r.run) else $error("serial stop ignored");
  rev_forbid_a: assert property (@(posedge clk) disable iff (rst)
    (st_r.run && st_r.reverse_run_terminal && st_r.dir == 2'd2) |-> tgt == 18'sd0)
    else $error("reverse not held at zero");
  low_stop_a: assert property (@(posedge clk) disable iff (rst)
    (st_r.lowAct == 2'd2 && setF < $signed({1'b0, st_r.lowF})) |=> !st_r.run)
    else $error("below lower limit still running");
  updn_hold_a: assert property (@(posedge clk) disable iff (rst)
    (st_r.pin[2] && st_r.pin[3] && !wrNow && st_r.started && !(st_r.run && !st_nxt.run))
    |=> $stable(st_r.offset)) else $error("both terminals moved set-point");
  phase_inv_a: assert property (@(posedge clk) disable iff (rst)
    (st_r.dir == 2'd1 && !st_r.reverse_run_terminal) ##1 (st_r.dir == 2'd1 && !st_r.reverse_run_terminal) |=> st_r.revPh)
    else $error("phase not inverted");
endmodule

/* frc_top_test.sv */
/*
  frc_top_test: register and pin level bench for the set-point controller.
  Assumes a zero wait-state bus slave and pins driven by frc_pin_model.
*/
module frc_top_test
  import frc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, running, reversePhase;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans, ctrlMode;
  logic [2:0] hsize;
  logic [16:0] outFreq, f1;
  logic [7:0] pinReq;
  logic signed [17:0] pidReq;
  logic forward_run_terminal, reverse_run_terminal, up, dn, rset, jog, rkey, mkey;
  logic [11:0] pot;
  logic [16:0] ain, nvo;
  logic signed [17:0] pid, plc;
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] badStore [4] = '{32'h02, 32'h08, 32'h20, 32'hc0};

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #25 clk = ~clk;

  frc_top uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .forwardRunTerminal(forward_run_terminal),
    .reverseRunTerminal(reverse_run_terminal), .upTerminal(up), .downTerminal(dn),
    .rampSetTerminal(rset), .jogTerminal(jog), .runKey(rkey), .multiPurposeKey(mkey),
    .potLevel(pot), .analogInput(ain), .pidFreq(pid), .plcFreq(plc), .nvOffset(nvo),
    .running(running), .reversePhase(reversePhase), .outFreq(outFreq),
    .ctrlMode(ctrlMode));

  frc_pin_model pins (.clk(clk), .pinReq(pinReq), .pidReq(pidReq),
    .forwardRunTerminal(forward_run_terminal), .reverseRunTerminal(reverse_run_terminal), .upTerminal(up),
    .downTerminal(dn), .rampSetTerminal(rset), .jogTerminal(jog), .runKey(rkey),
    .multiPurposeKey(mkey), .potLevel(pot), .analogInput(ain), .pidFreq(pid),
    .plcFreq(plc), .nvOffset(nvo));

  task automatic summarize();
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one bus phase: hold until ready is seen high at a rising edge
  task automatic waitBus();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      err_count++;
      summarize();
    end
  endtask

  task automatic busXfer(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitBus();
    htrans <= 2'h0;
    hwdata <= wd;
    waitBus();
    rdv = hrdata;
  endtask

  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    busXfer(a, 1'b0, 32'h0);
    check(nm, rdv, exp);
  endtask

  // write, then read back what the register must now hold
  task automatic wrChk(input string nm, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp);
    busXfer(a, 1'b1, d);
    rdChk(nm, a, exp);
  endtask

  // ramps are slow, so the wait is long but still bounded
  task automatic waitFreq(input logic [16:0] t);
    int n;
    n = 0;
    while (outFreq !== t && n < 20000) begin
      @(posedge clk);
      n++;
    end
    check("outFreq", {15'h0, outFreq}, {15'h0, t});
    if (n >= 20000) begin
      summarize();
    end
  endtask

  initial begin
    clk = 0;
    rst = 1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    pinReq = 8'h00;
    pidReq = 18'sh00000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values and an unmapped word
    rdChk("maxf", FRC_MAXF_OFF, 32'h1388);
    rdChk("upf", FRC_UPF_OFF, 32'h1388);
    rdChk("lowf", FRC_LOWF_OFF, 32'h0);
    rdChk("dset", FRC_DSET_OFF, 32'h1388);
    rdChk("store", FRC_STORE_OFF, 32'h0);
    rdChk("acc", FRC_ACC_OFF, 32'h00640064);
    rdChk("unmapped", 8'h30, 32'h0);
    // limit writes beyond each bound, and at the maxf, store and acc bounds
    wrChk("maxf", FRC_MAXF_OFF, 32'h1387, 32'h1388);
    wrChk("maxf", FRC_MAXF_OFF, 32'h1869d, 32'h1388);
    wrChk("maxf", FRC_MAXF_OFF, 32'h1869c, 32'h1869c);
    wrChk("upf", FRC_UPF_OFF, 32'h9, 32'h1388);
    wrChk("upf", FRC_UPF_OFF, 32'h1869d, 32'h1388);
    wrChk("lowf", FRC_LOWF_OFF, 32'h1389, 32'h0);
    wrChk("maxf", FRC_MAXF_OFF, 32'h1387, 32'h1869c);
    wrChk("maxf", FRC_MAXF_OFF, 32'h1388, 32'h1388);
    wrChk("dset", FRC_DSET_OFF, 32'h1389, 32'h1388);
    for (int i = 0; i < 4; i++) begin
      wrChk("store", FRC_STORE_OFF, badStore[i], 32'h0);
    end
    wrChk("store", FRC_STORE_OFF, 32'h95, 32'h95);
    wrChk("store", FRC_STORE_OFF, 32'h0, 32'h0);
    wrChk("acc", FRC_ACC_OFF, 32'h0, 32'h00640064);
    wrChk("acc", FRC_ACC_OFF, 32'h270f270f, 32'h270f270f);
    wrChk("acc", FRC_ACC_OFF, 32'h27102710, 32'h270f270f);
    wrChk("acc", FRC_ACC_OFF, 32'h00010001, 32'h00010001);
    wrChk("dset", FRC_DSET_OFF, 32'h14, 32'h14);
    busXfer(FRC_SRC_OFF, 1'b1, {29'h0, FRC_SRC_DIG});
    for (int m = 0; m < 3; m++) begin
      busXfer(FRC_CMD_OFF, 1'b1, m << FRC_MODE_LSB);
      repeat (4) @(posedge clk);
      check("ctrlMode", {30'h0, ctrlMode}, m);
    end
    // keypad channel ignores the run terminal, obeys the keys
    pinReq <= 8'h01;
    repeat (20) @(posedge clk);
    check("running", {31'h0, running}, 32'h0);
    pinReq <= 8'h41;
    repeat (10) @(posedge clk);
    pinReq <= 8'h01;
    repeat (10) @(posedge clk);
    check("running", {31'h0, running}, 32'h1);
    pinReq <= 8'h81;
    repeat (10) @(posedge clk);
    pinReq <= 8'h01;
    repeat (10) @(posedge clk);
    check("running", {31'h0, running}, 32'h0);
    busXfer(FRC_CMD_OFF, 1'b1, 32'h01000002);
    repeat (10) @(posedge clk);
    check("running", {31'h0, running}, 32'h1);
    busXfer(FRC_CMD_OFF, 1'b1, 32'h2);
    repeat (10) @(posedge clk);
    check("running", {31'h0, running}, 32'h0);
    busXfer(FRC_CMD_OFF, 1'b1, 32'h1);
    waitFreq(17'h14);
    rdChk("stat", FRC_STAT_OFF, 32'h40000014);
    // closed-loop output added to the main source
    pidReq <= 18'sh0000a;
    busXfer(FRC_STORE_OFF, 1'b1, 32'h40);
    waitFreq(17'h1e);
    busXfer(FRC_STORE_OFF, 1'b1, 32'h0);
    waitFreq(17'h14);
    // terminal adjustment starts from the stored set-point
    busXfer(FRC_SRC_OFF, 1'b1, {29'h0, FRC_SRC_UPDN});
    waitFreq(17'h14);
    pinReq <= 8'h05;
    repeat (4000) @(posedge clk);
    pinReq <= 8'h01;
    repeat (3000) @(posedge clk);
    f1 = outFreq;
    check("upRaise", {31'h0, f1 > 17'h14}, 32'h1);
    pinReq <= 8'h0d;
    repeat (3000) @(posedge clk);
    check("bothHold", {15'h0, outFreq}, {15'h0, f1});
    pinReq <= 8'h09;
    repeat (4000) @(posedge clk);
    pinReq <= 8'h01;
    repeat (3000) @(posedge clk);
    check("downLower", {31'h0, outFreq < f1}, 32'h1);
    // stop with restore-on-stop, then restart at the stored set-point
    busXfer(FRC_SRC_OFF, 1'b1, {29'h0, FRC_SRC_DIG});
    busXfer(FRC_STORE_OFF, 1'b1, 32'h04);
    pinReq <= 8'h00;
    waitFreq(17'h0);
    busXfer(FRC_STORE_OFF, 1'b1, 32'h0);
    pinReq <= 8'h01;
    waitFreq(17'h14);
    // set-point below the lower limit, each action in turn
    busXfer(FRC_LOWF_OFF, 1'b1, 32'h28);
    busXfer(FRC_CMD_OFF, 1'b1, 32'h11);
    waitFreq(17'h28);
    busXfer(FRC_CMD_OFF, 1'b1, 32'h01);
    waitFreq(17'h0);
    busXfer(FRC_CMD_OFF, 1'b1, 32'h21);
    repeat (20) @(posedge clk);
    check("running", {31'h0, running}, 32'h0);
    busXfer(FRC_LOWF_OFF, 1'b1, 32'h0);
    pinReq <= 8'h00;
    repeat (10) @(posedge clk);
    // direction codes: inverted phase order, then reverse forbidden
    busXfer(FRC_CMD_OFF, 1'b1, 32'h101);
    pinReq <= 8'h01;
    repeat (20) @(posedge clk);
    check("reversePhase", {31'h0, reversePhase}, 32'h1);
    busXfer(FRC_CMD_OFF, 1'b1, 32'h201);
    pinReq <= 8'h02;
    repeat (20) @(posedge clk);
    check("reversePhase", {31'h0, reversePhase}, 32'h0);
    waitFreq(17'h0);
    // second ramp set is slow: 10 s for full span, so no step in 4000 cycles
    busXfer(FRC_CMD_OFF, 1'b1, 32'h1);
    pinReq <= 8'h11;
    repeat (4000) @(posedge clk);
    check("slowSet", {15'h0, outFreq}, 32'h0);
    pinReq <= 8'h01;
    waitFreq(17'h14);
    summarize();
  end
endmodule
